//--- design/dar_defs.svh
// Purpose: constants for the converter status and result register block
// Assumes: 8-bit special-function-register bus, one core clock
// Notes: offsets are SFR byte addresses
`ifndef DAR_DEFS_SVH
`define DAR_DEFS_SVH
`define DAR_ADR_STATUS   8'hD8
`define DAR_ADR_MODE     8'hD1
`define DAR_ADR_P_RES_L  8'hD9
`define DAR_ADR_P_RES_M  8'hDA
`define DAR_ADR_P_RES_H  8'hDB
`define DAR_ADR_A_RES_L  8'hDC
`define DAR_ADR_A_RES_H  8'hDD
`define DAR_ADR_P_OFS_L  8'hE1
`define DAR_ADR_P_OFS_M  8'hE2
`define DAR_ADR_P_OFS_H  8'hE3
`define DAR_ADR_A_OFS_L  8'hE4
`define DAR_ADR_A_OFS_H  8'hE5
`define DAR_ADR_P_GN_L   8'hE9
`define DAR_ADR_P_GN_M   8'hEA
`define DAR_ADR_P_GN_H   8'hEB
`define DAR_ADR_A_GN_L   8'hEC
`define DAR_ADR_A_GN_H   8'hED
`define DAR_STATUS_RST   8'h00
`define DAR_MODE_RST     8'h00
`define DAR_P_OFS_RST    24'h800000
`define DAR_A_OFS_RST    16'h8000
`define DAR_P_GN_RST     24'h53_5555
`define DAR_A_GN_RST     16'h599A
`define DAR_BIT_P_RDY    3'd7
`define DAR_BIT_A_RDY    3'd6
`define DAR_BIT_CAL      3'd5
`define DAR_BIT_NOREF    3'd4
`define DAR_BIT_P_ERR    3'd3
`define DAR_BIT_A_ERR    3'd2
`define DAR_STATUS_USED  8'hFC
`define DAR_MODE_USED    8'h37
`define DAR_MODE_P_EN    5
`define DAR_MODE_A_EN    4
`define DAR_SYNC_LEN     3
`endif

//--- design/dar_pkg.sv
// Purpose: types for the converter status and result register block
// Assumes: dar_defs.svh holds every number except the mode encodings, which are defined here
// Notes: none
package dar_pkg;
    // mode field encodings of the three-bit mode select field
    typedef enum logic [2:0] {
        DAR_MD_OFF    = 3'b000,
        DAR_MD_IDLE   = 3'b001,
        DAR_MD_SINGLE = 3'b010,
        DAR_MD_CONT   = 3'b011,
        DAR_MD_CAL4   = 3'b100,
        DAR_MD_CAL5   = 3'b101,
        DAR_MD_CAL6   = 3'b110,
        DAR_MD_CAL7   = 3'b111
    } dar_mode_e;

    // one completion report from a converter core
    typedef struct packed {
        logic        done;
        logic        is_cal;
        logic        clamped;
        logic        cal_fault;
        logic [23:0] result;
        logic [23:0] offset;
        logic [23:0] gain;
    } dar_done_s;

    // special-function-register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bit_wr;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } dar_sfr_s;
endpackage

//--- design/dar_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin levels
// Assumes: input is asynchronous to CLK_IN
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "dar_defs.svh"
module dar_sync (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic ce_in,
    input  wire logic async_in,
    output var  logic level_out
);
    typedef struct packed {
        logic [`DAR_SYNC_LEN-1:0] stage;
        logic                     level;
    } dar_sync_s;

    dar_sync_s st_ff;
    dar_sync_s nxt_st;

    // shift the pin in; first stage feeds only the second
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stage = {st_ff.stage[1:0], async_in};
        if (st_ff.stage[1] == st_ff.stage[2]) begin
            nxt_st.level = st_ff.stage[2];
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_ff <= '0;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign level_out = st_ff.level;
endmodule
`default_nettype wire

//--- design/dar_flags.sv
// Purpose: ready and error flag pair for one converter
// Assumes: completion pulse and mode-write pulse from the same clock
// Notes: set wins over any clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
module dar_flags (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic ce_in,
    input  wire logic done_in,
    input  wire logic err_in,
    input  wire logic sw_clr_rdy_in,
    input  wire logic mode_wr_in,
    output var  logic ready_out,
    output var  logic error_out,
    output logic      accept_out
);
    typedef struct packed {
        logic rdy;
        logic err;
    } dar_flg_s;

    dar_flg_s st_ff;
    dar_flg_s nxt_st;

    // results land only while ready is clear
    assign accept_out = done_in && !st_ff.rdy;

    // flag next state: set has priority over clears
    always_comb begin
        nxt_st = st_ff;
        if (sw_clr_rdy_in || mode_wr_in) begin
            nxt_st.rdy = 1'b0;
        end
        if (mode_wr_in) begin
            nxt_st.err = 1'b0;
        end
        if (accept_out) begin
            nxt_st.rdy = 1'b1;
            if (err_in) begin
                nxt_st.err = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_ff <= '0;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign ready_out = st_ff.rdy;
    assign error_out = st_ff.err;

    property p_set_on_done;
        @(posedge clk_in) disable iff (!reset_n_in)
        ce_in && accept_out |=> st_ff.rdy;
    endproperty
    a_set_on_done: assert property (p_set_on_done)
        else $error("ready not set after completion");
endmodule
`default_nettype wire

//--- design/dar_top.sv
// Purpose: status, result and coefficient registers of two converters
// Assumes: core SFR bus, single clock, converter cores report completion
// Notes: result bytes and coefficients are writable only by hardware
//        except the coefficients, which software may also write
`timescale 1ns/100ps
`default_nettype none
`include "dar_defs.svh"
module dar_top (
    input  wire logic           CLK_IN,
    input  wire logic           RESET_N_IN,
    input  wire logic           CE_IN,
    input  wire dar_pkg::dar_sfr_s SFR_REQ_IN,
    output var  logic [7:0]     SFR_RDATA_OUT,
    output var  logic           SFR_HIT_OUT,
    input  wire dar_pkg::dar_done_s P_DONE_IN,
    input  wire dar_pkg::dar_done_s A_DONE_IN,
    input  wire logic           REF_LOW_IN,
    input  wire logic           EXT_REF_SEL_IN,
    output var  logic [2:0]     MODE_OUT,
    output var  logic           P_RUN_OUT,
    output var  logic           A_RUN_OUT
);
    import dar_pkg::*;

    typedef struct packed {
        logic       cal;
        logic       noref;
        logic [7:0] mode;
        logic [23:0] p_res;
        logic [15:0] a_res;
        logic [23:0] p_ofs;
        logic [15:0] a_ofs;
        logic [23:0] p_gn;
        logic [15:0] a_gn;
        logic [7:0] rdata;
    } dar_top_s;

    dar_top_s st_ff;
    dar_top_s nxt_st;
    logic     ref_low;
    logic     p_rdy;
    logic     a_rdy;
    logic     p_err;
    logic     a_err;
    logic     p_acc;
    logic     a_acc;
    logic     mode_wr;
    logic     stat_wr;
    logic     clr_p;
    logic     clr_a;
    logic     active;
    logic     p_err_in;
    logic     a_err_in;
    logic [7:0] status;

    // reference detect pin synchronised
    dar_sync u_ref_sync (
        .clk_in     (CLK_IN),
        .reset_n_in (RESET_N_IN),
        .ce_in      (CE_IN),
        .async_in   (REF_LOW_IN),
        .level_out  (ref_low)
    );

    // software write decode
    assign mode_wr = SFR_REQ_IN.wr && SFR_REQ_IN.addr == `DAR_ADR_MODE;
    assign stat_wr = SFR_REQ_IN.addr == `DAR_ADR_STATUS && SFR_REQ_IN.wr;
    // bit write touches one flag; byte write may clear both ready bits
    assign clr_p = stat_wr && (SFR_REQ_IN.bit_wr
        ? (SFR_REQ_IN.bit_sel == `DAR_BIT_P_RDY && !SFR_REQ_IN.wdata[0])
        : !SFR_REQ_IN.wdata[`DAR_BIT_P_RDY]);
    assign clr_a = stat_wr && (SFR_REQ_IN.bit_wr
        ? (SFR_REQ_IN.bit_sel == `DAR_BIT_A_RDY && !SFR_REQ_IN.wdata[0])
        : !SFR_REQ_IN.wdata[`DAR_BIT_A_RDY]);
    assign active = st_ff.mode[`DAR_MODE_P_EN] || st_ff.mode[`DAR_MODE_A_EN];

    // error cause: clamp on a conversion, fault on a calibration
    assign p_err_in = P_DONE_IN.is_cal ? P_DONE_IN.cal_fault
                                       : P_DONE_IN.clamped;
    assign a_err_in = A_DONE_IN.is_cal ? A_DONE_IN.cal_fault
                                       : A_DONE_IN.clamped;

    dar_flags u_p_flags (
        .clk_in        (CLK_IN),
        .reset_n_in    (RESET_N_IN),
        .ce_in         (CE_IN),
        .done_in       (P_DONE_IN.done),
        .err_in        (p_err_in),
        .sw_clr_rdy_in (clr_p),
        .mode_wr_in    (mode_wr),
        .ready_out     (p_rdy),
        .error_out     (p_err),
        .accept_out    (p_acc)
    );

    dar_flags u_a_flags (
        .clk_in        (CLK_IN),
        .reset_n_in    (RESET_N_IN),
        .ce_in         (CE_IN),
        .done_in       (A_DONE_IN.done),
        .err_in        (a_err_in),
        .sw_clr_rdy_in (clr_a),
        .mode_wr_in    (mode_wr),
        .ready_out     (a_rdy),
        .error_out     (a_err),
        .accept_out    (a_acc)
    );

    // status byte; reserved bits read zero
    assign status = {p_rdy, a_rdy, st_ff.cal, st_ff.noref,
                     p_err, a_err, 2'b00};

    // next state of all registers
    always_comb begin
        nxt_st = st_ff;
        // missing reference only while a converter runs
        nxt_st.noref = active && ref_low;
        if (mode_wr) begin
            nxt_st.cal  = 1'b0;
            nxt_st.mode = SFR_REQ_IN.wdata & `DAR_MODE_USED;
        end
        if (SFR_REQ_IN.wr) begin
            unique case (SFR_REQ_IN.addr)
                `DAR_ADR_P_OFS_L: nxt_st.p_ofs[7:0]   = SFR_REQ_IN.wdata;
                `DAR_ADR_P_OFS_M: nxt_st.p_ofs[15:8]  = SFR_REQ_IN.wdata;
                `DAR_ADR_P_OFS_H: nxt_st.p_ofs[23:16] = SFR_REQ_IN.wdata;
                `DAR_ADR_A_OFS_L: nxt_st.a_ofs[7:0]   = SFR_REQ_IN.wdata;
                `DAR_ADR_A_OFS_H: nxt_st.a_ofs[15:8]  = SFR_REQ_IN.wdata;
                `DAR_ADR_P_GN_L:  nxt_st.p_gn[7:0]    = SFR_REQ_IN.wdata;
                `DAR_ADR_P_GN_M:  nxt_st.p_gn[15:8]   = SFR_REQ_IN.wdata;
                `DAR_ADR_P_GN_H:  nxt_st.p_gn[23:16]  = SFR_REQ_IN.wdata;
                `DAR_ADR_A_GN_L:  nxt_st.a_gn[7:0]    = SFR_REQ_IN.wdata;
                `DAR_ADR_A_GN_H:  nxt_st.a_gn[15:8]   = SFR_REQ_IN.wdata;
                default: ;
            endcase
        end
        // primary completion, blocked while ready is still set
        if (p_acc) begin
            if (P_DONE_IN.is_cal) begin
                nxt_st.cal = 1'b1;
                if (!P_DONE_IN.cal_fault) begin
                    nxt_st.p_ofs = P_DONE_IN.offset;
                    nxt_st.p_gn  = P_DONE_IN.gain;
                end
            end else if (st_ff.noref && EXT_REF_SEL_IN) begin
                nxt_st.p_res = '1;
            end else begin
                nxt_st.p_res = P_DONE_IN.result;
            end
        end
        // auxiliary completion, same shape at 16 bits
        if (a_acc) begin
            if (A_DONE_IN.is_cal) begin
                nxt_st.cal = 1'b1;
                if (!A_DONE_IN.cal_fault) begin
                    nxt_st.a_ofs = A_DONE_IN.offset[15:0];
                    nxt_st.a_gn  = A_DONE_IN.gain[15:0];
                end
            end else if (st_ff.noref && EXT_REF_SEL_IN) begin
                nxt_st.a_res = '1;
            end else begin
                nxt_st.a_res = A_DONE_IN.result[15:0];
            end
        end
        // single conversion done returns mode field to power-down
        if ((p_acc || a_acc) && st_ff.mode[2:0] == DAR_MD_SINGLE
            && !mode_wr) begin
            nxt_st.mode[2:0] = DAR_MD_OFF;
        end
        // registered read data
        unique case (SFR_REQ_IN.addr)
            `DAR_ADR_STATUS:  nxt_st.rdata = status;
            `DAR_ADR_MODE:    nxt_st.rdata = st_ff.mode;
            `DAR_ADR_P_RES_L: nxt_st.rdata = st_ff.p_res[7:0];
            `DAR_ADR_P_RES_M: nxt_st.rdata = st_ff.p_res[15:8];
            `DAR_ADR_P_RES_H: nxt_st.rdata = st_ff.p_res[23:16];
            `DAR_ADR_A_RES_L: nxt_st.rdata = st_ff.a_res[7:0];
            `DAR_ADR_A_RES_H: nxt_st.rdata = st_ff.a_res[15:8];
            `DAR_ADR_P_OFS_L: nxt_st.rdata = st_ff.p_ofs[7:0];
            `DAR_ADR_P_OFS_M: nxt_st.rdata = st_ff.p_ofs[15:8];
            `DAR_ADR_P_OFS_H: nxt_st.rdata = st_ff.p_ofs[23:16];
            `DAR_ADR_A_OFS_L: nxt_st.rdata = st_ff.a_ofs[7:0];
            `DAR_ADR_A_OFS_H: nxt_st.rdata = st_ff.a_ofs[15:8];
            `DAR_ADR_P_GN_L:  nxt_st.rdata = st_ff.p_gn[7:0];
            `DAR_ADR_P_GN_M:  nxt_st.rdata = st_ff.p_gn[15:8];
            `DAR_ADR_P_GN_H:  nxt_st.rdata = st_ff.p_gn[23:16];
            `DAR_ADR_A_GN_L:  nxt_st.rdata = st_ff.a_gn[7:0];
            `DAR_ADR_A_GN_H:  nxt_st.rdata = st_ff.a_gn[15:8];
            default:          nxt_st.rdata = 8'h00;
        endcase
    end

    // state register with factory coefficient values at reset
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            st_ff       <= '0;
            st_ff.mode  <= `DAR_MODE_RST;
            st_ff.p_ofs <= `DAR_P_OFS_RST;
            st_ff.a_ofs <= `DAR_A_OFS_RST;
            st_ff.p_gn  <= `DAR_P_GN_RST;
            st_ff.a_gn  <= `DAR_A_GN_RST;
        end else if (CE_IN) begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign SFR_RDATA_OUT = st_ff.rdata;
    assign SFR_HIT_OUT   = SFR_REQ_IN.rd || SFR_REQ_IN.wr;
    assign MODE_OUT      = st_ff.mode[2:0];
    assign P_RUN_OUT     = st_ff.mode[`DAR_MODE_P_EN];
    assign A_RUN_OUT     = st_ff.mode[`DAR_MODE_A_EN];

    property p_rdy_blocks;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && p_rdy && P_DONE_IN.done && !P_DONE_IN.is_cal
        |=> $stable(st_ff.p_res);
    endproperty
    a_rdy_blocks: assert property (p_rdy_blocks)
        else $error("result written while ready set");

    property p_clamp_ones;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && p_acc && !P_DONE_IN.is_cal && st_ff.noref && EXT_REF_SEL_IN
        |=> st_ff.p_res == 24'hFFFFFF;
    endproperty
    a_clamp_ones: assert property (p_clamp_ones)
        else $error("result not forced to ones");

    property p_cal_clear;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && mode_wr && !p_acc && !a_acc |=> !st_ff.cal;
    endproperty
    a_cal_clear: assert property (p_cal_clear)
        else $error("calibration flag not cleared by mode write");

    property p_cal_set;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && p_acc && P_DONE_IN.is_cal |=> st_ff.cal && p_rdy;
    endproperty
    a_cal_set: assert property (p_cal_set)
        else $error("calibration done not flagged");

    property p_noref_idle;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && !P_RUN_OUT && !A_RUN_OUT |=> !st_ff.noref;
    endproperty
    a_noref_idle: assert property (p_noref_idle)
        else $error("missing reference flagged while idle");

    property p_err_clear;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && mode_wr && !p_acc |=> !p_err && !p_rdy;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("primary flags not cleared by mode write");

    property p_single_off;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && p_acc && !mode_wr && MODE_OUT == DAR_MD_SINGLE
        |=> MODE_OUT == DAR_MD_OFF;
    endproperty
    a_single_off: assert property (p_single_off)
        else $error("single conversion did not return to power-down");

    property p_reserved_zero;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && SFR_REQ_IN.addr == `DAR_ADR_STATUS
        |=> SFR_RDATA_OUT[1:0] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bits not zero");

    property p_status_read;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && SFR_REQ_IN.addr == `DAR_ADR_STATUS
        |=> SFR_RDATA_OUT == $past(status);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read data does not match the flags");

    property p_a_rdy_blocks;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && a_rdy && A_DONE_IN.done && !A_DONE_IN.is_cal
        |=> $stable(st_ff.a_res);
    endproperty
    a_a_rdy_blocks: assert property (p_a_rdy_blocks)
        else $error("auxiliary result written while ready set");

    property p_noref_set;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && active && ref_low |=> st_ff.noref;
    endproperty
    a_noref_set: assert property (p_noref_set)
        else $error("missing reference not flagged while running");

    property p_noref_valid;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && !ref_low |=> !st_ff.noref;
    endproperty
    a_noref_valid: assert property (p_noref_valid)
        else $error("missing reference flagged with valid reference");

    property p_clr_keeps;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        CE_IN && stat_wr && SFR_REQ_IN.bit_wr
        && SFR_REQ_IN.bit_sel == `DAR_BIT_P_RDY && !p_acc && !a_acc
        |=> $stable(a_rdy) && $stable(a_err) && $stable(p_err)
            && $stable(st_ff.cal);
    endproperty
    a_clr_keeps: assert property (p_clr_keeps)
        else $error("single-bit ready clear disturbed other flags");
endmodule
`default_nettype wire

//--- verification/dar_top_tb.sv
// Purpose: self-checking bench for the converter status and result block
// Assumes: dar_defs.svh addresses, one 20 MHz core clock, sync reset
// Notes: bus and completion tasks drive on the rising edge by non-blocking
//        assignment; assertions live in the design files
`timescale 1ns/100ps
`default_nettype none
`include "dar_defs.svh"
module dar_top_tb;
    import dar_pkg::*;

    localparam logic [7:0] ST_A = `DAR_ADR_STATUS;
    localparam logic [7:0] MD_A = `DAR_ADR_MODE;
    // reset map: results, offsets, factory gains, one unmapped place
    localparam logic [7:0] RA_TAB [18] = '{8'hD8, 8'hD1, 8'hD9, 8'hDA,
        8'hDB, 8'hDC, 8'hDD, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE9,
        8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hDE};
    localparam logic [7:0] RV_TAB [18] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h55,
        8'h55, 8'h53, 8'h9A, 8'h59, 8'h00};

    logic       clk_in     = 1'b0;
    logic       reset_n_in = 1'b0;
    logic       ce         = 1'b1;
    dar_sfr_s   req        = '0;
    dar_done_s  p_done     = '0;
    dar_done_s  a_done     = '0;
    logic       ref_low    = 1'b0;
    logic       ext_sel    = 1'b0;
    logic [7:0] rdata;
    logic       hit;
    logic [2:0] mode;
    logic       p_run;
    logic       a_run;
    int         mismatches = 0;
    int         n_tests    = 0;
    int         cycles     = 0;

    // design under test
    dar_top dar_top_i (
        .CLK_IN         (clk_in),
        .RESET_N_IN     (reset_n_in),
        .CE_IN          (ce),
        .SFR_REQ_IN     (req),
        .SFR_RDATA_OUT  (rdata),
        .SFR_HIT_OUT    (hit),
        .P_DONE_IN      (p_done),
        .A_DONE_IN      (a_done),
        .REF_LOW_IN     (ref_low),
        .EXT_REF_SEL_IN (ext_sel),
        .MODE_OUT       (mode),
        .P_RUN_OUT      (p_run),
        .A_RUN_OUT      (a_run)
    );

    // 50 ns core clock
    always #25 clk_in = ~clk_in;

    // hang guard, well above the roughly 175 cycles the run needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    // counts and verdict, the single exit
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input string n, input logic [23:0] got,
                       input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask

    // byte write, or single-bit write of d[0] when b is set
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic b = 1'b0, input logic [2:0] s = 3'd0);
        @(posedge clk_in);
        req <= '{1'b1, 1'b0, b, a, s, d};
        @(posedge clk_in);
        req <= '0;
    endtask

    // read: data is registered at the taking edge
    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge clk_in);
        req <= '{1'b0, 1'b1, 1'b0, a, 3'd0, 8'h00};
        #1;
        chk("sfr_hit", {23'h0, hit}, 24'h1);
        @(posedge clk_in);
        req <= '0;
        #1;
        chk(n, {16'h0, rdata & m}, {16'h0, e});
    endtask

    // one completion report from a converter core
    task automatic fire(input logic aux, input logic cal, input logic clp,
                        input logic flt, input logic [23:0] res,
                        input logic [23:0] ofs = '0,
                        input logic [23:0] gn = '0);
        dar_done_s d;
        d = '{1'b1, cal, clp, flt, res, ofs, gn};
        @(posedge clk_in);
        if (aux) begin
            a_done <= d;
        end else begin
            p_done <= d;
        end
        @(posedge clk_in);
        p_done <= '0;
        a_done <= '0;
    endtask

    task automatic tdone(input string n);
        $display("test %s done", n);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // refused writes, then the whole reset map
        wr(8'hD9, 8'h77);
        wr(8'hDE, 8'h5A);
        for (int i = 0; i < 18; i++) begin
            rd_chk("reset_value", RA_TAB[i], RV_TAB[i]);
        end
        tdone("reset");
        // single conversion on the primary converter, then completions on both converters
        wr(MD_A, 8'h32);
        fire(1'b0, 1'b0, 1'b0, 1'b0, 24'h123456);
        rd_chk("status", ST_A, 8'h80);
        rd_chk("p_res_l", 8'hD9, 8'h56);
        rd_chk("p_res_m", 8'hDA, 8'h34);
        rd_chk("p_res_h", 8'hDB, 8'h12);
        chk("mode_out", {21'h0, mode}, 24'h0);
        rd_chk("mode_reg", MD_A, 8'h30);
        chk("p_run", {23'h0, p_run}, 24'h1);
        fire(1'b0, 1'b0, 1'b1, 1'b0, 24'hABCDEF);
        rd_chk("p_res_l", 8'hD9, 8'h56);
        rd_chk("status", ST_A, 8'h80);
        fire(1'b1, 1'b0, 1'b1, 1'b0, 24'h00FFFF);
        rd_chk("status", ST_A, 8'hC4);
        rd_chk("a_res_l", 8'hDC, 8'hFF);
        rd_chk("a_res_h", 8'hDD, 8'hFF);
        fire(1'b1, 1'b0, 1'b0, 1'b0, 24'h000011);
        rd_chk("a_res_l", 8'hDC, 8'hFF);
        tdone("conversion");
        // software clears and reserved bits
        wr(ST_A, 8'h00, 1'b1, 3'd7);
        rd_chk("status", ST_A, 8'h44);
        wr(ST_A, 8'hFF);
        rd_chk("status", ST_A, 8'h44);
        wr(ST_A, 8'h01, 1'b1, 3'd0);
        rd_chk("status", ST_A, 8'h44);
        wr(MD_A, 8'h33);
        rd_chk("status", ST_A, 8'h00);
        chk("mode_out", {21'h0, mode}, 24'h3);
        chk("a_run", {23'h0, a_run}, 24'h1);
        fire(1'b0, 1'b0, 1'b1, 1'b0, 24'h000000);
        rd_chk("status", ST_A, 8'h88);
        wr(MD_A, 8'h33);
        rd_chk("status", ST_A, 8'h00);
        tdone("clears");
        // calibration, then a faulted one
        fire(1'b0, 1'b1, 1'b0, 1'b0, 24'h0, 24'h0A0B0C, 24'h0D0E0F);
        fire(1'b1, 1'b1, 1'b0, 1'b0, 24'h0, 24'h001122, 24'h003344);
        rd_chk("status", ST_A, 8'hE0);
        rd_chk("p_ofs_l", 8'hE1, 8'h0C);
        rd_chk("p_ofs_h", 8'hE3, 8'h0A);
        rd_chk("a_ofs_h", 8'hE5, 8'h11);
        rd_chk("p_gn_m", 8'hEA, 8'h0E);
        rd_chk("p_gn_h", 8'hEB, 8'h0D);
        rd_chk("a_gn_l", 8'hEC, 8'h44);
        wr(ST_A, 8'h00, 1'b1, 3'd7);
        rd_chk("status", ST_A, 8'h60);
        fire(1'b0, 1'b1, 1'b0, 1'b1, 24'h0, 24'h111111, 24'h222222);
        rd_chk("status", ST_A, 8'hE8);
        rd_chk("p_ofs_l", 8'hE1, 8'h0C);
        rd_chk("p_gn_l", 8'hE9, 8'h0F);
        wr(MD_A, 8'h33);
        rd_chk("status", ST_A, 8'h00);
        // completion while the clock enable is low must be lost
        @(posedge clk_in);
        ce <= 1'b0;
        fire(1'b0, 1'b0, 1'b0, 1'b0, 24'h000042);
        @(posedge clk_in);
        ce <= 1'b1;
        rd_chk("ce_hold", ST_A, 8'h00);
        rd_chk("ce_hold_res", 8'hD9, 8'h00);
        tdone("calibration");
        // missing reference with external reference selected
        @(posedge clk_in);
        ext_sel <= 1'b1;
        ref_low <= 1'b1;
        repeat (10) @(posedge clk_in);
        rd_chk("noref", ST_A, 8'h10, 8'h10);
        fire(1'b0, 1'b0, 1'b0, 1'b0, 24'h000123);
        rd_chk("p_res_l", 8'hD9, 8'hFF);
        rd_chk("p_res_m", 8'hDA, 8'hFF);
        rd_chk("p_res_h", 8'hDB, 8'hFF);
        @(posedge clk_in);
        ref_low <= 1'b0;
        repeat (10) @(posedge clk_in);
        rd_chk("noref", ST_A, 8'h00, 8'h10);
        tdone("reference");
        end_sim();
    end
endmodule
`default_nettype wire
